/* File: bcf_alu.sv */
// Purpose: result and zero/nibble-carry/carry values of one instruction
// Assumes: f_val already carries the literal for literal forms
// Notes: purely combinational; flags are {zero, nibble carry, carry}
module bcf_alu
   import bcf_pkg::*;
(
   input bcf_op_type op,
   input logic [7:0] w_val,
   input logic [7:0] f_val,
   input logic [2:0] bit_sel,
   input logic carry_in,
   output logic [7:0] result,
   output logic [2:0] flags,
   output logic [2:0] flag_mask
);
   // returns {carry, nibble carry, sum}
   function automatic logic [9:0] add_c(input logic [7:0] a, input logic [7:0] b, input logic cin);
      logic [4:0] lo;
      logic [8:0] full;
      lo = {1'h0, a[3:0]} + {1'h0, b[3:0]} + {4'h0, cin};
      full = {1'h0, a} + {1'h0, b} + {8'h00, cin};
      return {full[8], lo[4], full[7:0]};
   endfunction

   logic [9:0] sum;

   always_comb begin
      sum = 10'h000;
      result = f_val;
      flags = 3'h0;
      flag_mask = 3'h0;
      case (op)
         add_w_file_op, add_literal_op: begin
            sum = add_c(f_val, w_val, 1'h0);
            result = sum[7:0];
            flags = {sum[7:0] == 8'h00, sum[8], sum[9]};
            flag_mask = MASK_ALL;
         end
         sub_w_file_op, sub_literal_op: begin
            // borrow shows as inverted carry
            sum = add_c(f_val, ~w_val, 1'h1);
            result = sum[7:0];
            flags = {sum[7:0] == 8'h00, sum[8], sum[9]};
            flag_mask = MASK_ALL;
         end
         and_op, ior_op, xor_op, move_file_op: begin
            case (op)
               and_op: result = w_val & f_val;
               ior_op: result = w_val | f_val;
               xor_op: result = w_val ^ f_val;
               default: result = f_val;
            endcase
            flags = {result == 8'h00, 2'h0};
            flag_mask = MASK_Z;
         end
         rotate_left_op: begin
            result = {f_val[6:0], carry_in};
            flags = {2'h0, f_val[7]};
            flag_mask = MASK_C;
         end
         rotate_right_op: begin
            result = {carry_in, f_val[7:1]};
            flags = {2'h0, f_val[0]};
            flag_mask = MASK_C;
         end
         nibble_exchange_op: result = {f_val[3:0], f_val[7:4]};
         w_to_file_op: result = w_val;
         file_zeroing_op: begin
            result = 8'h00;
            flags = MASK_Z;
            flag_mask = MASK_Z;
         end
         bit_zero_op: result = f_val & ~(8'h01 << bit_sel);
         bit_one_op: result = f_val | (8'h01 << bit_sel);
         default: result = f_val;
      endcase
   end
endmodule

/* File: bcf_core_model.sv */
// Purpose: instruction issue side of the core, facing the banked flag register file
// Assumes: one instruction per exec call, single core clock
// Notes: idle offset, W, literal and bit lines carry inverted data so stale values are never trusted; the dest line keeps its value
module bcf_core_model
   import bcf_pkg::*;
(
   input logic aclk,
   output bcf_op_type core_op,
   output logic core_op_valid,
   output logic [6:0] core_ofs,
   output logic core_dest_file,
   output logic [7:0] core_w,
   output logic [7:0] core_lit,
   output logic [2:0] core_bit
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      core_op = op_none;
      {core_op_valid, core_ofs, core_dest_file, core_w, core_lit, core_bit} = '0;
   end

   task automatic exec(input bcf_op_type op, input logic [6:0] ofs, input logic dest,
      input logic [7:0] w, input logic [7:0] lit = 8'h00, input logic [2:0] bt = 3'h0);
      @(posedge aclk);
      core_op <= op;
      core_op_valid <= 1'b1;
      core_ofs <= ofs;
      core_dest_file <= dest;
      core_w <= w;
      core_lit <= lit;
      core_bit <= bt;
      @(posedge aclk);
      core_op <= op_none;
      core_op_valid <= 1'b0;
      core_ofs <= ~ofs;
      core_w <= ~w;
      core_lit <= ~lit;
      core_bit <= ~bt;
      #1;
   endtask

   // software touches flags only through ops that leave every flag alone
   task automatic flag_bit(input logic val, input logic [2:0] bt);
      exec(val ? bit_one_op : bit_zero_op, STATUS_OFS, 1'b1, 8'h00, 8'h00, bt);
   endtask
endmodule

/* File: bcf_pkg.sv */
// Purpose: shared constants and types for the banked flag register file
// Assumes: 8-bit data memory, 5-bit bank number, 7-bit bank offset
// Notes: enumerations carry no explicit codes
package bcf_pkg;
   localparam int unsigned BANKS = 32;
   localparam int unsigned BANK_BYTES = 128;
   localparam int unsigned CORE_N = 12;
   localparam int unsigned PERIPH_N = 20;
   localparam int unsigned GPR_N = 80;
   localparam int unsigned COMMON_N = 16;
   localparam logic [6:0] PERIPH_LO = 7'h0C;
   localparam logic [6:0] PERIPH_HI = 7'h1F;
   localparam logic [6:0] GPR_LO = 7'h20;
   localparam logic [6:0] COMMON_LO = 7'h70;
   localparam logic [6:0] STATUS_OFS = 7'h03;
   localparam logic [6:0] BANKPTR_OFS = 7'h08;
   localparam int unsigned TIMEOUT_BIT = 4;
   localparam int unsigned SLEEP_BIT = 3;
   localparam int unsigned Z_BIT = 2;
   localparam int unsigned NIBBLE_BIT = 1;
   localparam int unsigned C_BIT = 0;
   localparam logic [4:0] STATUS_POR = 5'h18;
   localparam logic [2:0] MASK_ALL = 3'h7;
   localparam logic [2:0] MASK_Z = 3'h4;
   localparam logic [2:0] MASK_C = 3'h1;
   localparam int unsigned AXI_IDX_LO = 2;
   localparam int unsigned AXI_IDX_HI = 13;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   typedef enum logic [4:0] {
      op_none, add_w_file_op, sub_w_file_op, add_literal_op, sub_literal_op,
      and_op, ior_op, xor_op, move_file_op, rotate_left_op, rotate_right_op,
      nibble_exchange_op, w_to_file_op, file_zeroing_op, bit_zero_op, bit_one_op,
      watchdog_clear_op, sleep_op
   } bcf_op_type;

   typedef enum logic [2:0] {
      reg_none, reg_core, reg_periph, reg_gpr, reg_common
   } bcf_region_type;
endpackage

/* File: bcf_regfile.sv */
// Purpose: banked data memory with shared core group and flag register
// Assumes: core issues one instruction per enabled cycle on ofs in active bank
// Notes: AXI4-Lite sees all banks; byte address = 4 * data memory address
module bcf_regfile
   import bcf_pkg::*;
#(
   parameter int unsigned NB = BANKS,
   parameter int unsigned GB = GPR_N,
   parameter int unsigned ADDR_W = 16
) (
   input logic aclk,
   input logic aresetn,
   input logic ce,
   input logic core_op_valid,
   input bcf_op_type core_op,
   input logic [6:0] core_ofs,
   input logic core_dest_file,
   input logic [7:0] core_w,
   input logic [7:0] core_lit,
   input logic [2:0] core_bit,
   output logic [7:0] core_result_q,
   output logic [7:0] arith_reset_flags,
   input logic wdt_timeout,
   input logic rst_evt,
   input logic rst_evt_tmo,
   input logic rst_evt_slp,
   input logic [ADDR_W-1:0] s_axi_awaddr,
   input logic s_axi_awvalid,
   output logic s_axi_awready,
   input logic [31:0] s_axi_wdata,
   input logic [3:0] s_axi_wstrb,
   input logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input logic s_axi_bready,
   input logic [ADDR_W-1:0] s_axi_araddr,
   input logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input logic s_axi_rready
);
   ////////////////////////////////////////////////////////////////////////////
   logic [7:0] core_mem [CORE_N];
   logic [7:0] periph_mem [NB*PERIPH_N];
   logic [7:0] gpr_mem [NB*GB];
   logic [7:0] common_mem [COMMON_N];
   logic [4:0] flags_q;
   logic [4:0] flags_d;
   logic [4:0] bank_q;

   function automatic bcf_region_type region_of(input logic [4:0] bank, input logic [6:0] ofs);
      bcf_region_type r;
      r = reg_none;
      if (ofs < PERIPH_LO) begin
         r = reg_core;
      end else if (ofs <= PERIPH_HI) begin
         if (32'(bank) < NB) r = reg_periph;
      end else if (ofs < COMMON_LO) begin
         // banks past NB and bytes past GB stay unimplemented
         if (32'(bank) < NB && 32'(ofs - GPR_LO) < GB) r = reg_gpr;
      end else begin
         r = reg_common;
      end
      return r;
   endfunction

   function automatic int periph_idx(input logic [4:0] bank, input logic [6:0] ofs);
      return int'(bank) * PERIPH_N + int'(ofs - PERIPH_LO);
   endfunction

   function automatic int gpr_idx(input logic [4:0] bank, input logic [6:0] ofs);
      return int'(bank) * GB + int'(ofs - GPR_LO);
   endfunction

   function automatic logic [7:0] mem_read(input logic [4:0] bank, input logic [6:0] ofs);
      logic [7:0] v;
      v = 8'h00;
      case (region_of(bank, ofs))
         reg_core: begin
            if (ofs == STATUS_OFS) v = {3'h0, flags_q};
            else if (ofs == BANKPTR_OFS) v = {3'h0, bank_q};
            else v = core_mem[ofs[3:0]];
         end
         reg_periph: v = periph_mem[periph_idx(bank, ofs)];
         reg_gpr: v = gpr_mem[gpr_idx(bank, ofs)];
         reg_common: v = common_mem[ofs[3:0]];
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // instruction side
   logic core_go;
   logic core_wf;
   logic core_st;
   logic [7:0] f_rd;
   logic [7:0] alu_f;
   logic [7:0] alu_res;
   logic [2:0] alu_flags;
   logic [2:0] alu_mask;

   always_comb begin
      core_go = ce & core_op_valid;
      core_st = core_ofs == STATUS_OFS;
      f_rd = mem_read(bank_q, core_ofs);
      alu_f = (core_op inside {add_literal_op, sub_literal_op}) ? core_lit : f_rd;
      case (core_op)
         w_to_file_op, file_zeroing_op, bit_zero_op, bit_one_op: core_wf = 1'h1;
         add_w_file_op, sub_w_file_op, and_op, ior_op, xor_op, move_file_op,
         rotate_left_op, rotate_right_op, nibble_exchange_op: core_wf = core_dest_file;
         default: core_wf = 1'h0;
      endcase
   end

   bcf_alu u_alu (
      .op(core_op),
      .w_val(core_w),
      .f_val(alu_f),
      .bit_sel(core_bit),
      .carry_in(flags_q[C_BIT]),
      .result(alu_res),
      .flags(alu_flags),
      .flag_mask(alu_mask)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         core_result_q <= 8'h00;
      end else if (core_go) begin
         core_result_q <= alu_res;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite capture
   logic aw_held_q;
   logic w_held_q;
   logic aw_bad_q;
   logic [11:0] aw_idx_q;
   logic [7:0] w_byte_q;
   logic w_lane_q;
   logic axi_wr_go;
   logic [11:0] ar_idx;
   logic ar_bad;

   assign s_axi_awready = ce & ~aw_held_q;
   assign s_axi_wready = ce & ~w_held_q;
   assign s_axi_arready = ce & ~s_axi_rvalid;
   assign ar_idx = s_axi_araddr[AXI_IDX_HI:AXI_IDX_LO];
   assign ar_bad = |s_axi_araddr[ADDR_W-1:AXI_IDX_HI+1];
   // core owns the single write port; the bus waits a cycle on conflict
   assign axi_wr_go = ce & aw_held_q & w_held_q & ~s_axi_bvalid & ~(core_go & core_wf);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'h0;
         w_held_q <= 1'h0;
         aw_bad_q <= 1'h0;
         aw_idx_q <= 12'h000;
         w_byte_q <= 8'h00;
         w_lane_q <= 1'h0;
         s_axi_bvalid <= 1'h0;
         s_axi_bresp <= RESP_OKAY;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'h1;
            aw_idx_q <= s_axi_awaddr[AXI_IDX_HI:AXI_IDX_LO];
            aw_bad_q <= |s_axi_awaddr[ADDR_W-1:AXI_IDX_HI+1];
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'h1;
            w_byte_q <= s_axi_wdata[7:0];
            w_lane_q <= s_axi_wstrb[0];
         end
         if (axi_wr_go) begin
            aw_held_q <= 1'h0;
            w_held_q <= 1'h0;
            s_axi_bvalid <= 1'h1;
            s_axi_bresp <= aw_bad_q ? RESP_DECERR : RESP_OKAY;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'h0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'h0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (ce) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'h1;
            s_axi_rdata <= {24'h00_0000, ar_bad ? 8'h00 : mem_read(ar_idx[11:7], ar_idx[6:0])};
            s_axi_rresp <= ar_bad ? RESP_DECERR : RESP_OKAY;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'h0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // shared write port
   logic wr_en;
   logic wr_core;
   logic [4:0] wr_bank;
   logic [6:0] wr_ofs;
   logic [7:0] wr_data;

   always_comb begin
      wr_core = core_go & core_wf;
      wr_en = wr_core | (axi_wr_go & w_lane_q & ~aw_bad_q);
      wr_bank = wr_core ? bank_q : aw_idx_q[11:7];
      wr_ofs = wr_core ? core_ofs : aw_idx_q[6:0];
      wr_data = wr_core ? alu_res : w_byte_q;
   end

   always_ff @(posedge aclk) begin
      if (wr_en) begin
         case (region_of(wr_bank, wr_ofs))
            reg_core: begin
               if (wr_ofs != STATUS_OFS && wr_ofs != BANKPTR_OFS) core_mem[wr_ofs[3:0]] <= wr_data;
            end
            reg_periph: periph_mem[periph_idx(wr_bank, wr_ofs)] <= wr_data;
            reg_gpr: gpr_mem[gpr_idx(wr_bank, wr_ofs)] <= wr_data;
            reg_common: common_mem[wr_ofs[3:0]] <= wr_data;
            default: ;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bank_q <= 5'h00;
      end else if (wr_en && wr_ofs == BANKPTR_OFS) begin
         bank_q <= wr_data[4:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // flag register
   always_comb begin
      flags_d = flags_q;
      if (wr_en && wr_ofs == STATUS_OFS && !(wr_core && alu_mask != 3'h0)) begin
         flags_d[2:0] = wr_data[2:0];
      end
      if (core_go) begin
         flags_d[2:0] = (alu_flags & alu_mask) | (flags_d[2:0] & ~alu_mask);
      end
      if (core_go && core_op == watchdog_clear_op) begin
         flags_d[TIMEOUT_BIT] = 1'h1;
         flags_d[SLEEP_BIT] = 1'h1;
      end
      if (core_go && core_op == sleep_op) begin
         flags_d[TIMEOUT_BIT] = 1'h1;
         flags_d[SLEEP_BIT] = 1'h0;
      end
      if (rst_evt) begin
         flags_d[TIMEOUT_BIT] = rst_evt_tmo;
         flags_d[SLEEP_BIT] = rst_evt_slp;
      end
      // a timeout outranks any same-cycle clear or sleep
      if (wdt_timeout) begin
         flags_d[TIMEOUT_BIT] = 1'h0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flags_q <= STATUS_POR;
      end else if (ce) begin
         flags_q <= flags_d;
      end
   end

   assign arith_reset_flags = {3'h0, flags_q};

   ////////////////////////////////////////////////////////////////////////////
   default clocking clk_cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence st_rd_s;
      s_axi_arvalid && s_axi_arready && !ar_bad && ar_idx[6:0] == STATUS_OFS;
   endsequence

   sequence st_axi_wr_s;
      axi_wr_go && w_lane_q && !aw_bad_q && aw_idx_q[6:0] == STATUS_OFS && !wdt_timeout && !rst_evt && !core_go;
   endsequence

   sequence core_plain_s;
      core_go && !core_st && !rst_evt;
   endsequence

   por_flags_a: assert property ($rose(aresetn) |-> flags_q == STATUS_POR)
      else $error("flags not at power-on value");
   status_rd_a: assert property (st_rd_s |=> s_axi_rdata[7:5] == 3'h0 && s_axi_rdata[4:0] == $past(flags_q))
      else $error("flag register read wrong");
   ro_bits_a: assert property (st_axi_wr_s |=> flags_q[4:3] == $past(flags_q[4:3]))
      else $error("timeout or sleep flag written");
   plain_wr_a: assert property (st_axi_wr_s |=> flags_q[2:0] == $past(w_byte_q[2:0]))
      else $error("flag write lost");
   zero_status_a: assert property (core_go && core_st && core_op == file_zeroing_op && !rst_evt
      |=> flags_q[Z_BIT] && flags_q[1:0] == $past(flags_q[1:0]))
      else $error("zeroing flags wrong");
   wdt_clear_a: assert property (ce && wdt_timeout |=> !flags_q[TIMEOUT_BIT])
      else $error("timeout flag not cleared");
   sleep_flags_a: assert property (core_go && core_op == sleep_op && !wdt_timeout && !rst_evt
      |=> flags_q[4:3] == 2'h2)
      else $error("sleep flags wrong");
   add_carry_a: assert property (core_plain_s and core_op == add_w_file_op
      |=> flags_q[NIBBLE_BIT] == ({1'h0, $past(core_w[3:0])} + {1'h0, $past(f_rd[3:0])} > 5'h0F)
      && flags_q[C_BIT] == ({1'h0, $past(core_w)} + {1'h0, $past(f_rd)} > 9'h0FF))
      else $error("add carries wrong");
   sub_borrow_a: assert property (core_plain_s and core_op == sub_w_file_op
      |=> flags_q[C_BIT] == ($past(f_rd) >= $past(core_w)))
      else $error("subtract borrow wrong");
   zero_and_a: assert property (core_plain_s and core_op == and_op
      |=> flags_q[Z_BIT] == (($past(core_w) & $past(f_rd)) == 8'h00))
      else $error("zero flag wrong");
   rot_carry_a: assert property (core_plain_s and core_op == rotate_left_op
      |=> flags_q[C_BIT] == $past(f_rd[7]))
      else $error("rotate carry wrong");
   bank_sel_a: assert property (core_go && core_op == w_to_file_op && core_ofs == BANKPTR_OFS
      |=> bank_q == $past(core_w[4:0]))
      else $error("bank pointer not loaded");
   unimpl_rd_a: assert property (s_axi_arvalid && s_axi_arready
      && region_of(ar_idx[11:7], ar_idx[6:0]) == reg_none |=> s_axi_rdata == 32'h0000_0000)
      else $error("unimplemented read not zero");
endmodule

/* File: test_banked_core_flags_regfile.sv */
// Purpose: self-checking bench for the banked flag register file
// Assumes: one core instruction at a time, memory reached over AXI4-Lite
// Notes: general RAM cut to 64 bytes so an unbacked tail of a bank is reachable
module test_banked_core_flags_regfile;
   timeunit 1ns;
   timeprecision 1ps;
   import bcf_pkg::*;

   localparam logic [15:0] FLAGS_A = 16'h000C;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic wdt_timeout = 1'b0, rst_evt = 1'b0, rst_evt_tmo = 1'b0, rst_evt_slp = 1'b0;
   logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
   logic [31:0] wdata = 32'h00000000;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [7:0] result, flags;
   bcf_op_type c_op;
   logic c_valid, c_dest;
   logic [6:0] c_ofs;
   logic [7:0] c_w, c_lit;
   logic [2:0] c_bit;
   int fail_count = 0;
   int n_compared = 0;

   always #2 aclk = ~aclk;

   bcf_core_model u_core (.aclk(aclk), .core_op(c_op), .core_op_valid(c_valid), .core_ofs(c_ofs),
      .core_dest_file(c_dest), .core_w(c_w), .core_lit(c_lit), .core_bit(c_bit));

   bcf_regfile #(.GB(64)) DUT (
      .aclk(aclk), .aresetn(aresetn), .ce(1'b1), .core_op_valid(c_valid), .core_op(c_op),
      .core_ofs(c_ofs), .core_dest_file(c_dest), .core_w(c_w), .core_lit(c_lit), .core_bit(c_bit),
      .core_result_q(result), .arith_reset_flags(flags), .wdt_timeout(wdt_timeout),
      .rst_evt(rst_evt), .rst_evt_tmo(rst_evt_tmo), .rst_evt_slp(rst_evt_slp),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   ////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic hang();
      fail_count++;
      $display("[ERR] handshake expected done seen stuck");
      tally_and_finish();
   endtask

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic cf(input logic [7:0] exp);
      chk("flags", flags, exp);
   endtask

   function automatic logic [15:0] ad(input int b, input logic [6:0] o);
      return 16'((b * 128 + int'(o)) * 4);
   endfunction

   // address and data go out together and are dropped one by one as taken
   task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
      bit aw_ok;
      bit w_ok;
      int i;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      i = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (i++ > 50) hang();
         if (!aw_ok && awready === 1'b1) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wready === 1'b1) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end while (!(aw_ok && w_ok));
      do begin
         @(posedge aclk);
         if (i++ > 100) hang();
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk("bresp", bresp, er);
   endtask

   task automatic rd(input logic [15:0] a, input logic [7:0] ed, input logic [1:0] er = RESP_OKAY);
      int i;
      i = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (i++ > 50) hang();
      end while (arready !== 1'b1);
      arvalid <= 1'b0;
      do begin
         @(posedge aclk);
         if (i++ > 100) hang();
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk("rdata", rdata, {24'h000000, ed});
      chk("rresp", rresp, er);
   endtask

   task automatic pulse(input logic tmo, input logic slp, input logic dog);
      @(posedge aclk);
      rst_evt <= ~dog;
      rst_evt_tmo <= tmo;
      rst_evt_slp <= slp;
      wdt_timeout <= dog;
      @(posedge aclk);
      rst_evt <= 1'b0;
      wdt_timeout <= 1'b0;
      #1;
   endtask

   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      #1;
      cf(8'h18);
      chk("result", result, 8'h00);
      rd(ad(9, STATUS_OFS), 8'h18);
      wr(FLAGS_A, 8'hFF);
      rd(FLAGS_A, 8'h1F);
      wr(FLAGS_A, 8'h00);
      cf(8'h18);
      wr(ad(4, 7'h0B), 8'h5A);
      rd(ad(0, 7'h0B), 8'h5A);
      wr(ad(1, PERIPH_LO), 8'h71);
      wr(ad(2, PERIPH_HI), 8'h72);
      wr(ad(3, PERIPH_HI), 8'h73);
      rd(ad(1, PERIPH_LO), 8'h71);
      rd(ad(2, PERIPH_HI), 8'h72);
      wr(ad(0, 7'h7F), 8'hA5);
      rd(ad(31, 7'h7F), 8'hA5);
      wr(ad(0, GPR_LO), 8'h11);
      wr(ad(31, GPR_LO), 8'h22);
      rd(ad(0, GPR_LO), 8'h11);
      rd(ad(31, GPR_LO), 8'h22);
      wr(ad(2, 7'h5F), 8'h33);
      rd(ad(2, 7'h5F), 8'h33);
      wr(ad(2, 7'h60), 8'h44);
      rd(ad(2, 7'h60), 8'h00);
      wr(ad(0, 7'h00), 8'h66);
      wr(16'h4000, 8'h55, RESP_DECERR);
      rd(16'h4000, 8'h00, RESP_DECERR);
      rd(ad(0, 7'h00), 8'h66);
      // bank five picked through the pointer, bank zero must stay untouched
      wr(ad(0, BANKPTR_OFS), 8'h05);
      wr(ad(5, GPR_LO), 8'h0F);
      u_core.exec(add_w_file_op, GPR_LO, 1'b1, 8'h01);
      cf(8'h1A);
      chk("result", result, 8'h10);
      rd(ad(5, GPR_LO), 8'h10);
      rd(ad(0, GPR_LO), 8'h11);
      u_core.exec(add_w_file_op, GPR_LO, 1'b1, 8'hF0);
      cf(8'h1D);
      u_core.exec(sub_w_file_op, GPR_LO, 1'b0, 8'h01);
      cf(8'h18);
      chk("result", result, 8'hFF);
      u_core.exec(sub_literal_op, GPR_LO, 1'b1, 8'h05, 8'h05);
      cf(8'h1F);
      u_core.exec(add_literal_op, GPR_LO, 1'b1, 8'h08, 8'h08);
      cf(8'h1A);
      wr(ad(5, 7'h21), 8'h81);
      u_core.exec(rotate_left_op, 7'h21, 1'b1, 8'h00);
      cf(8'h1B);
      chk("result", result, 8'h02);
      u_core.exec(rotate_right_op, 7'h21, 1'b0, 8'h00);
      cf(8'h1A);
      chk("result", result, 8'h81);
      // a zero sum written back to the flags must not clear timeout or sleep
      u_core.exec(add_w_file_op, STATUS_OFS, 1'b1, 8'hE6);
      cf(8'h1F);
      wr(FLAGS_A, 8'h01);
      u_core.exec(file_zeroing_op, STATUS_OFS, 1'b1, 8'h00);
      cf(8'h1D);
      u_core.flag_bit(1'b0, 3'h0);
      u_core.flag_bit(1'b1, 3'h1);
      cf(8'h1E);
      u_core.exec(sleep_op, GPR_LO, 1'b0, 8'h00);
      cf(8'h16);
      pulse(1'b0, 1'b0, 1'b1);
      cf(8'h06);
      u_core.exec(watchdog_clear_op, GPR_LO, 1'b0, 8'h00);
      cf(8'h1E);
      pulse(1'b0, 1'b1, 1'b0);
      cf(8'h0E);
      @(posedge aclk);
      aresetn <= 1'b0;
      @(posedge aclk);
      aresetn <= 1'b1;
      #1;
      cf(8'h18);
      rd(ad(0, BANKPTR_OFS), 8'h00);
      u_core.exec(add_w_file_op, GPR_LO, 1'b1, 8'h01);
      rd(ad(0, GPR_LO), 8'h12);
      // pointer loaded by the core itself, then flag-only and flag-neutral ops
      u_core.exec(w_to_file_op, BANKPTR_OFS, 1'b1, 8'h05);
      rd(ad(0, BANKPTR_OFS), 8'h05);
      u_core.exec(and_op, GPR_LO, 1'b0, 8'hF0);
      cf(8'h1C);
      chk("result", result, 8'h00);
      u_core.exec(nibble_exchange_op, STATUS_OFS, 1'b1, 8'h00);
      cf(8'h19);
      tally_and_finish();
   end
endmodule
